// ---- src/pwm_defs.svh ----
// constants of the four-channel pulse width modulator with brake
`ifndef PWM_DEFS_SVH
`define PWM_DEFS_SVH

// register indexes; byte address is four times the index
`define IDX_PERIOD_LO 8'hD9
`define IDX_PERIOD_HI 8'hD1
`define IDX_CMP0_LO 8'hDA
`define IDX_CMP1_LO 8'hDB
`define IDX_CMP2_LO 8'hDD
`define IDX_CMP3_LO 8'hDE
`define IDX_CMP0_HI 8'hD2
`define IDX_CMP1_HI 8'hD3
`define IDX_CMP2_HI 8'hD5
`define IDX_CMP3_HI 8'hD6
`define IDX_CTRL0 8'hDC
`define IDX_CTRL1 8'hDF
`define IDX_CTRL2 8'hD7

// control 0 bits
`define C0_RUN 7
`define C0_LOAD 6
`define C0_FLAG 5
`define C0_CLEAR 4
// control 1 bits
`define C1_MODE 7
`define C1_POL 6
`define C1_PIN_EN 5
`define C1_EN 4
// control 2 bits
`define C2_FP_HI 3
`define C2_FP_LO 2
`define C2_FLAG 0

// widths, reset values and special values
`define CNT_W 10
`define REG_RESET 8'h00
`define CNT_RESET 10'h000
`define CNT_ZERO 10'h000
`define CMP_ALL_ONES 10'h3FF
`define OUT_RESET 1'b1
`define HI_MASK 8'h03
`define C2_MASK 8'h0D
`define PRE_RESET 4'h0
`define PRE_MASK_1 4'h0
`define PRE_MASK_2 4'h1
`define PRE_MASK_4 4'h3
`define PRE_MASK_16 4'hF

// bus answers
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`define WORD_ZERO 32'h0000_0000

`endif

// ---- src/pwm_pkg.sv ----
// types shared by the modulator files
package pwm_pkg;

	// fields of control register 0
	typedef struct packed {
		logic       run;
		logic       load;
		logic       flag;
		logic       clear;
		logic [3:0] invert;
	} ctrl0_t;

	// fields of the brake control register
	typedef struct packed {
		logic       mode_select;
		logic       polarity;
		logic       pin_enable;
		logic       enable;
		logic [3:0] level;
	} brake_ctrl_t;

	// per-channel settings handed to each output stage
	typedef struct packed {
		logic [9:0] compare;
		logic       invert;
		logic       brake_level;
	} chan_cfg_t;

endpackage : pwm_pkg

// ---- src/pwm_channel.sv ----
// one output stage: compare, hold, invert and brake override
`timescale 1ns/1ns
`default_nettype none
`include "pwm_defs.svh"

module pwm_channel (
	input  wire logic              clk,
	input  wire logic              rst_b,
	input  wire logic [9:0]        count,
	input  wire pwm_pkg::chan_cfg_t cfg,
	input  wire logic              update,
	input  wire logic              brake,
	output var  logic              pwm_out
);

	logic held;
	logic cmp_level;
	logic next_held;
	logic next_out;

	// all ones is forced low even when a count loaded from an all-ones period reaches it
	assign cmp_level = (cfg.compare != `CMP_ALL_ONES) && !(count < cfg.compare);
	// level only tracks while running and not braked
	assign next_held = update ? cmp_level : held;
	assign next_out = brake ? cfg.brake_level : (next_held ^ cfg.invert);

	// held level survives a brake so it can be restored afterwards
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			held    <= `OUT_RESET;
			pwm_out <= `OUT_RESET;
		end else begin
			held    <= next_held;
			pwm_out <= next_out;
		end
	end

endmodule : pwm_channel
`default_nettype wire

// ---- src/four_channel_pwm_with_brake.sv ----
// four-channel 10-bit modulator with brake, behind an axi4-lite slave
`timescale 1ns/1ns
`default_nettype none
`include "pwm_defs.svh"

module four_channel_pwm_with_brake (
	input  wire logic        clk,
	input  wire logic        rst_b,
	// axi4-lite write address
	input  wire logic [11:0] awaddr,
	input  wire logic        awvalid,
	output var  logic        awready,
	// axi4-lite write data
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	input  wire logic        wvalid,
	output var  logic        wready,
	// axi4-lite write response
	output var  logic [1:0]  bresp,
	output var  logic        bvalid,
	input  wire logic        bready,
	// axi4-lite read address
	input  wire logic [11:0] araddr,
	input  wire logic        arvalid,
	output var  logic        arready,
	// axi4-lite read data
	output var  logic [31:0] rdata,
	output var  logic [1:0]  rresp,
	output var  logic        rvalid,
	input  wire logic        rready,
	// pins
	input  wire logic        brake_input_pin,
	output var  logic [3:0]  pwm_out
);

	// =====================================================
	// register state
	logic [7:0]            period_lo;
	logic [1:0]            period_hi;
	logic [7:0]            cmp_lo [4];
	logic [1:0]            cmp_hi [4];
	pwm_pkg::ctrl0_t       ctrl0;
	pwm_pkg::brake_ctrl_t  brake_ctrl;
	logic [1:0]            prescale_sel;
	logic                  pin_brake_flag;

	// working copies and counter
	logic [9:0]            period_work;
	logic [9:0]            cmp_work [4];
	logic [9:0]            count;
	logic [3:0]            pre_cnt;
	logic                  load_done;

	localparam logic [7:0] CMP_LO_IDX [4] = '{`IDX_CMP0_LO, `IDX_CMP1_LO,
		`IDX_CMP2_LO, `IDX_CMP3_LO};
	localparam logic [7:0] CMP_HI_IDX [4] = '{`IDX_CMP0_HI, `IDX_CMP1_HI,
		`IDX_CMP2_HI, `IDX_CMP3_HI};

	// =====================================================
	// write channel: address and data taken in either order
	logic        aw_held;
	logic        w_held;
	logic [9:0]  aw_word;
	logic [7:0]  w_byte;
	logic        w_lane0;
	logic        do_write;
	logic [7:0]  wr_idx;
	logic        wr_hit;

	assign awready  = !aw_held && !bvalid;
	assign wready   = !w_held && !bvalid;
	assign do_write = aw_held && w_held && !bvalid;
	// indexes fit in 8 bits; upper index bits must be zero to hit
	assign wr_idx   = aw_word[7:0];

	// capture address and data, then answer once both are in
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			aw_held <= 1'b0;
			w_held  <= 1'b0;
			aw_word <= 10'h000;
			w_byte  <= `REG_RESET;
			w_lane0 <= 1'b0;
			bvalid  <= 1'b0;
			bresp   <= `RESP_OKAY;
		end else begin
			if (awvalid && awready) begin
				aw_held <= 1'b1;
				aw_word <= awaddr[11:2];
			end
			if (wvalid && wready) begin
				w_held  <= 1'b1;
				w_byte  <= wdata[7:0];
				w_lane0 <= wstrb[0];
			end
			if (do_write) begin
				aw_held <= 1'b0;
				w_held  <= 1'b0;
				bvalid  <= 1'b1;
				bresp   <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
			end else if (bvalid && bready) begin
				bvalid <= 1'b0;
			end
		end
	end

	// =====================================================
	// address decode, shared by both directions
	function automatic logic idx_mapped(input logic [9:0] w);
		logic [7:0] i;
		i = w[7:0];
		idx_mapped = (w[9:8] == 2'h0) && (i == `IDX_PERIOD_LO || i == `IDX_PERIOD_HI
			|| i == `IDX_CMP0_LO || i == `IDX_CMP1_LO || i == `IDX_CMP2_LO
			|| i == `IDX_CMP3_LO || i == `IDX_CMP0_HI || i == `IDX_CMP1_HI
			|| i == `IDX_CMP2_HI || i == `IDX_CMP3_HI || i == `IDX_CTRL0
			|| i == `IDX_CTRL1 || i == `IDX_CTRL2);
	endfunction : idx_mapped

	logic we;
	logic we_ctrl0;
	logic we_ctrl1;
	logic we_ctrl2;
	logic we_per_lo;
	logic we_per_hi;

	assign wr_hit    = idx_mapped(aw_word);
	// only byte lane 0 carries register data
	assign we        = do_write && wr_hit && w_lane0;
	assign we_ctrl0  = we && (wr_idx == `IDX_CTRL0);
	assign we_ctrl1  = we && (wr_idx == `IDX_CTRL1);
	assign we_ctrl2  = we && (wr_idx == `IDX_CTRL2);
	assign we_per_lo = we && (wr_idx == `IDX_PERIOD_LO);
	assign we_per_hi = we && (wr_idx == `IDX_PERIOD_HI);

	// =====================================================
	// brake condition
	logic pin_active;
	logic pin_brake;
	logic brake;

	assign pin_active = (brake_input_pin == brake_ctrl.polarity);
	assign pin_brake  = brake_ctrl.enable && brake_ctrl.pin_enable
		&& !brake_ctrl.mode_select && pin_active;
	// both selects high is not a valid mode and never brakes
	assign brake = brake_ctrl.enable && (
		(!brake_ctrl.pin_enable && !brake_ctrl.mode_select)
		|| (!brake_ctrl.pin_enable && brake_ctrl.mode_select && !ctrl0.run)
		|| pin_brake);

	// =====================================================
	// prescaler and counter timing
	logic [3:0] pre_mask;
	logic       tick;
	logic       underflow;
	logic       transfer;

	assign pre_mask  = (prescale_sel == 2'h0) ? `PRE_MASK_1 :
		(prescale_sel == 2'h1) ? `PRE_MASK_2 :
		(prescale_sel == 2'h2) ? `PRE_MASK_4 : `PRE_MASK_16;
	assign tick      = ctrl0.run && ((pre_cnt & pre_mask) == pre_mask);
	assign underflow = tick && (count == `CNT_ZERO);
	// only an underflow moves buffers, and underflow needs run
	assign transfer  = underflow && ctrl0.load;

	// prescaler held in phase with the run bit
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			pre_cnt <= `PRE_RESET;
		end else begin
			pre_cnt <= ctrl0.run ? pre_cnt + 4'h1 : `PRE_RESET;
		end
	end

	// shared down counter; a clear write beats a reload
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			count <= `CNT_RESET;
		end else if (we_ctrl0 && w_byte[`C0_CLEAR]) begin
			count <= `CNT_ZERO;
		end else if (transfer) begin
			count <= {period_hi, period_lo};
		end else if (underflow) begin
			count <= period_work;
		end else if (tick) begin
			count <= count - 10'h001;
		end
	end

	// working period and compares change only at a transfer
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			period_work <= `CNT_RESET;
			for (int i = 0; i < 4; i++) begin
				cmp_work[i] <= `CNT_RESET;
			end
		end else if (transfer) begin
			period_work <= {period_hi, period_lo};
			for (int i = 0; i < 4; i++) begin
				cmp_work[i] <= {cmp_hi[i], cmp_lo[i]};
			end
		end
	end

	// =====================================================
	// control 0: run, load, flag, invert
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			ctrl0     <= pwm_pkg::ctrl0_t'(`REG_RESET);
			load_done <= 1'b0;
		end else begin
			load_done <= transfer;
			if (we_ctrl0) begin
				ctrl0.run    <= w_byte[`C0_RUN];
				// a write without load drops a pending transfer
				ctrl0.load   <= w_byte[`C0_LOAD];
				ctrl0.invert <= w_byte[3:0];
				ctrl0.flag   <= w_byte[`C0_FLAG] || underflow;
			end else begin
				if (load_done) begin
					ctrl0.load <= 1'b0;
				end
				if (underflow) begin
					ctrl0.flag <= 1'b1;
				end
			end
			// the pin overrides any software run in the same cycle
			if (pin_brake) begin
				ctrl0.run <= 1'b0;
			end
			ctrl0.clear <= 1'b0;
		end
	end

	// brake control and control 2
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			brake_ctrl     <= pwm_pkg::brake_ctrl_t'(`REG_RESET);
			prescale_sel   <= 2'h0;
			pin_brake_flag <= 1'b0;
		end else begin
			if (we_ctrl1) begin
				brake_ctrl <= pwm_pkg::brake_ctrl_t'(w_byte);
			end
			if (we_ctrl2) begin
				prescale_sel <= w_byte[`C2_FP_HI:`C2_FP_LO];
			end
			// set beats a software clear
			if (pin_brake) begin
				pin_brake_flag <= 1'b1;
			end else if (we_ctrl2) begin
				pin_brake_flag <= w_byte[`C2_FLAG];
			end
		end
	end

	// period and compare buffers; writes while load is up are not guarded
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			period_lo <= `REG_RESET;
			period_hi <= 2'h0;
			for (int i = 0; i < 4; i++) begin
				cmp_lo[i] <= `REG_RESET;
				cmp_hi[i] <= 2'h0;
			end
		end else begin
			if (we_per_lo) begin
				period_lo <= w_byte;
			end
			if (we_per_hi) begin
				period_hi <= w_byte[1:0];
			end
			for (int i = 0; i < 4; i++) begin
				if (we && wr_idx == CMP_LO_IDX[i]) begin
					cmp_lo[i] <= w_byte;
				end
				if (we && wr_idx == CMP_HI_IDX[i]) begin
					cmp_hi[i] <= w_byte[1:0];
				end
			end
		end
	end

	// =====================================================
	// read channel
	logic [9:0] ar_word;
	logic [7:0] rd_idx;
	logic       rd_hit;
	logic [7:0] rd_byte;
	logic [7:0] rd_cmp_lo;
	logic [7:0] rd_cmp_hi;

	assign arready = !rvalid;
	assign ar_word = araddr[11:2];
	assign rd_idx  = ar_word[7:0];
	assign rd_hit  = idx_mapped(ar_word);
	assign rd_cmp_lo = (rd_idx == `IDX_CMP0_LO) ? cmp_lo[0] :
		(rd_idx == `IDX_CMP1_LO) ? cmp_lo[1] :
		(rd_idx == `IDX_CMP2_LO) ? cmp_lo[2] :
		(rd_idx == `IDX_CMP3_LO) ? cmp_lo[3] : `REG_RESET;
	assign rd_cmp_hi = (rd_idx == `IDX_CMP0_HI) ? {6'h00, cmp_hi[0]} :
		(rd_idx == `IDX_CMP1_HI) ? {6'h00, cmp_hi[1]} :
		(rd_idx == `IDX_CMP2_HI) ? {6'h00, cmp_hi[2]} :
		(rd_idx == `IDX_CMP3_HI) ? {6'h00, cmp_hi[3]} : `REG_RESET;
	// the clear bit always reads zero; reserved bits read zero
	assign rd_byte = (rd_idx == `IDX_CTRL0) ? 8'(ctrl0) :
		(rd_idx == `IDX_CTRL1) ? 8'(brake_ctrl) :
		(rd_idx == `IDX_CTRL2) ? ({4'h0, prescale_sel, 1'b0, pin_brake_flag} & `C2_MASK) :
		(rd_idx == `IDX_PERIOD_LO) ? period_lo :
		(rd_idx == `IDX_PERIOD_HI) ? {6'h00, period_hi} :
		rd_cmp_lo | rd_cmp_hi;

	// one read at a time, answered one cycle after the address
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rvalid <= 1'b0;
			rdata  <= `WORD_ZERO;
			rresp  <= `RESP_OKAY;
		end else if (arvalid && arready) begin
			rvalid <= 1'b1;
			rdata  <= rd_hit ? {24'h000000, rd_byte} : `WORD_ZERO;
			rresp  <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
		end else if (rvalid && rready) begin
			rvalid <= 1'b0;
		end
	end

	// =====================================================
	// output stages
	logic track;

	// held levels freeze once run drops or brake takes over
	assign track = ctrl0.run && !brake;

	for (genvar c = 0; c < 4; c++) begin : g_chan
		pwm_pkg::chan_cfg_t cfg;
		assign cfg = '{compare: cmp_work[c], invert: ctrl0.invert[c],
			brake_level: brake_ctrl.level[c]};
		pwm_channel u_chan (
			.clk     (clk),
			.rst_b   (rst_b),
			.count   (count),
			.cfg     (cfg),
			.update  (track),
			.brake   (brake),
			.pwm_out (pwm_out[c])
		);
	end

endmodule : four_channel_pwm_with_brake
`default_nettype wire

// ---- testbench/pwm_port_checker_sva.sv ----
// port assertions for the four-channel modulator
`timescale 1ns/1ns
`default_nettype none
module pwm_port_checker (
	input wire logic        clk,
	input wire logic        rst_b,
	input wire logic        awvalid,
	input wire logic        awready,
	input wire logic        wvalid,
	input wire logic        wready,
	input wire logic [1:0]  bresp,
	input wire logic        bvalid,
	input wire logic        bready,
	input wire logic        arvalid,
	input wire logic        arready,
	input wire logic [31:0] rdata,
	input wire logic [1:0]  rresp,
	input wire logic        rvalid,
	input wire logic        rready,
	input wire logic [3:0]  pwm_out
);
	// ==========================================
	// helper state
	logic wrote;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_b);
	// nothing can start the counter before a write has landed
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) wrote <= 1'b0;
		else if (bvalid) wrote <= 1'b1;
	end
	// ==========================================
	// assertions
	a_idle_outputs: assert property (!(wrote || bvalid) |-> pwm_out == 4'hF)
		else $error("outputs moved before any write");
	// taken at one edge, register lands at the next, bvalid seen one edge later
	a_write_answer: assert property (awvalid && awready && wvalid && wready |-> ##2 bvalid)
		else $error("write answer late");
	a_read_answer: assert property (arvalid && arready |=> rvalid)
		else $error("read answer late");
	a_bresp_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
		else $error("write response dropped");
	a_rdata_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp))
		else $error("read data dropped");
	a_write_blocked: assert property (bvalid |-> !awready && !wready)
		else $error("write accepted during response");
	a_read_blocked: assert property (rvalid |-> !arready)
		else $error("read accepted during data");
	a_read_byte: assert property (rvalid |-> rdata[31:8] == 24'h0 && rresp != 2'h1)
		else $error("read word malformed");
	a_bvalid_drop: assert property (bvalid && bready |=> !bvalid)
		else $error("write response repeated");
endmodule : pwm_port_checker
bind four_channel_pwm_with_brake pwm_port_checker chk (
	.clk(clk), .rst_b(rst_b), .awvalid(awvalid), .awready(awready), .wvalid(wvalid),
	.wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .arvalid(arvalid),
	.arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
	.pwm_out(pwm_out)
);
`default_nettype wire

// ---- testbench/pwm_load_model.sv ----
// loads on the output pins and the brake switch
`timescale 1ns/1ns
`default_nettype none
module pwm_load_model (
	input  wire logic        clk,
	input  wire logic [3:0]  pwm_out,
	input  wire logic        count_en,
	input  wire logic        press,
	input  wire logic        press_level,
	output wire logic        brake_input_pin,
	output var  logic [15:0] high_cnt [4]
);
	logic was_en = 1'b0;
	// released switch shows the inverse level, never a stale one
	assign brake_input_pin = press ? press_level : ~press_level;
	// loads integrate high time; a new window restarts the sums
	always @(posedge clk) begin
		was_en <= count_en;
		for (int c = 0; c < 4; c++) begin
			if (count_en) high_cnt[c] <= (was_en ? high_cnt[c] : 16'h0) + 16'(pwm_out[c]);
		end
	end
endmodule : pwm_load_model
`default_nettype wire

// ---- testbench/test_four_channel_pwm_with_brake.sv ----
// self-checking bench of the four-channel modulator with brake
`timescale 1ns/1ns
`default_nettype none
`include "pwm_defs.svh"
module test_four_channel_pwm_with_brake;
	logic        clk = 1'b0;
	logic        rst_b, awvalid, wvalid, bready, arvalid, rready, meas, press, lvl;
	logic        awready, wready, bvalid, arready, rvalid, pin;
	logic [11:0] awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [3:0]  wstrb, pwm_out, inv, frz;
	logic [1:0]  bresp, rresp;
	logic [15:0] highs [4];
	logic [9:0]  per, nv;
	logic [9:0]  cmp [4];
	logic [7:0]  lo_idx [4] = '{`IDX_CMP0_LO, `IDX_CMP1_LO, `IDX_CMP2_LO, `IDX_CMP3_LO};
	logic [7:0]  hi_idx [4] = '{`IDX_CMP0_HI, `IDX_CMP1_HI, `IDX_CMP2_HI, `IDX_CMP3_HI};
	int          num_errors, n_checks, seed;
	// ==========================================
	// clock, design and far side
	always #5 clk = ~clk;
	four_channel_pwm_with_brake uut (.clk(clk), .rst_b(rst_b), .awaddr(awaddr),
		.awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
		.wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
		.arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
		.rready(rready), .brake_input_pin(pin), .pwm_out(pwm_out));
	pwm_load_model load (.clk(clk), .pwm_out(pwm_out), .count_en(meas), .press(press),
		.press_level(lvl), .brake_input_pin(pin), .high_cnt(highs));
	// ==========================================
	// helpers
	task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			num_errors++;
			$display("Error %s expected %0h seen %0h", what, e, g);
		end
	endtask : chk
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask : tick
	// handshakes are sampled at the falling edge, where every port is settled
	task automatic wr(input logic [7:0] idx, input logic [7:0] d, input logic [1:0] er);
		logic aw_ok, w_ok, b_ok;
		logic [1:0] r;
		int t;
		@(posedge clk);
		awaddr <= {2'h0, idx, 2'h0};
		wdata <= {24'h0, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		b_ok = 1'b0;
		for (t = 0; !b_ok && t < 100; t++) begin
			@(negedge clk);
			aw_ok = awvalid && awready;
			w_ok = wvalid && wready;
			b_ok = bvalid;
			r = bresp;
			@(posedge clk);
			if (aw_ok) awvalid <= 1'b0;
			if (w_ok) wvalid <= 1'b0;
		end
		bready <= 1'b1;
		@(posedge clk);
		bready <= 1'b0;
		chk($sformatf("write %0h", idx), {1'b1, er}, {b_ok, r});
	endtask : wr
	task automatic rd(input logic [7:0] idx, output logic [31:0] d, output logic [1:0] r);
		logic a_ok, v;
		int t;
		@(posedge clk);
		araddr <= {2'h0, idx, 2'h0};
		arvalid <= 1'b1;
		v = 1'b0;
		for (t = 0; !v && t < 100; t++) begin
			@(negedge clk);
			a_ok = arvalid && arready;
			v = rvalid;
			d = rdata;
			r = rresp;
			@(posedge clk);
			if (a_ok) arvalid <= 1'b0;
		end
		rready <= 1'b1;
		@(posedge clk);
		rready <= 1'b0;
		if (!v) r = 2'h1;
	endtask : rd
	// response code and data checked together; unmapped reads answer an error
	task automatic rc(input logic [7:0] idx, input logic [7:0] m, input logic [7:0] e,
		input logic [1:0] er = 2'h0);
		logic [31:0] d;
		logic [1:0]  r;
		rd(idx, d, r);
		chk($sformatf("read %0h", idx), {er, 22'h0, e}, {r, d[29:0] & {22'h3FFFFF, m}});
	endtask : rc
	task automatic poll_load;
		logic [31:0] d;
		logic [1:0]  r;
		d = 32'h0000_0040;
		for (int t = 0; d[6] && t < 60; t++) rd(`IDX_CTRL0, d, r);
		chk("load bit", 32'h0, {31'h0, d[6]});
	endtask : poll_load
	task automatic set_cmp(input int c, input logic [9:0] v);
		wr(hi_idx[c], {6'h0, v[9:8]}, 2'h0);
		wr(lo_idx[c], v[7:0], 2'h0);
	endtask : set_cmp
	task automatic window(input int n);
		tick(3);
		meas <= 1'b1;
		tick(n);
		meas <= 1'b0;
		tick(1);
	endtask : window
	// expected high cycles of one channel over k whole periods
	function automatic logic [15:0] exp_high(input int c, input int k);
		logic [15:0] h;
		h = (cmp[c] > per) ? 16'h0 : 16'(k * (per + 1 - cmp[c]));
		return inv[c] ? 16'(k * (per + 1)) - h : h;
	endfunction : exp_high
	task automatic measure(input int k);
		window(k * (per + 1));
		for (int c = 0; c < 4; c++) begin
			chk($sformatf("high time %0d", c), exp_high(c, k), highs[c]);
		end
	endtask : measure
	// waits at falling edges until channel 2 turns to level v
	task automatic edge2(input logic v);
		int t;
		t = 0;
		while (pwm_out[2] === v && t < 400) begin
			@(negedge clk);
			t++;
		end
		while (pwm_out[2] !== v && t < 400) begin
			@(negedge clk);
			t++;
		end
		chk("channel 2 edge", 32'h1, {31'h0, t < 400});
	endtask : edge2
	task automatic report_and_stop;
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : report_and_stop
	// ==========================================
	// watchdog, far above the expected run time
	initial begin
		#600000;
		num_errors++;
		report_and_stop();
	end
	// ==========================================
	// main sequence
	initial begin
		{awvalid, wvalid, bready, arvalid, rready, meas, press, lvl, rst_b} = 9'h000;
		{awaddr, araddr, wdata} = 56'h0;
		wstrb = 4'hF;
		inv = 4'h0;
		seed = 32'h6EF9;
		num_errors = 0;
		n_checks = 0;
		repeat (2) @(posedge clk);
		rst_b <= 1'b1;
		rc(`IDX_CTRL0, 8'hFF, 8'h00);
		rc(`IDX_CTRL1, 8'hFF, 8'h00);
		rc(8'h10, 8'hFF, 8'h00, 2'h2);
		wr(8'h10, 8'h55, 2'h2);
		wr(`IDX_CMP3_HI, 8'hFF, 2'h0);
		rc(`IDX_CMP3_HI, 8'hFF, 8'h03);
		// random period and duty, with the fixed-level corner cases
		per = 10'(90 + ($random(seed) & 31));
		cmp = '{10'h000, 10'h3FF, 10'(50 + ($random(seed) & 31)), 10'(per + 1 + ($random(seed) & 63))};
		wr(`IDX_PERIOD_HI, {6'h0, per[9:8]}, 2'h0);
		wr(`IDX_PERIOD_LO, per[7:0], 2'h0);
		for (int c = 0; c < 4; c++) set_cmp(c, cmp[c]);
		wr(`IDX_CTRL0, 8'hC0, 2'h0);
		poll_load();
		measure(2);
		rc(`IDX_CTRL0, 8'hFF, 8'hA0);
		inv = 4'h5;
		wr(`IDX_CTRL0, 8'h85, 2'h0);
		measure(1);
		inv = 4'h0;
		wr(`IDX_CTRL0, 8'h80, 2'h0);
		// clearing mid-high gives channel 2 exactly one low cycle
		edge2(1'b1);
		@(posedge clk);
		meas <= 1'b1;
		wr(`IDX_CTRL0, 8'h90, 2'h0);
		tick(2);
		meas <= 1'b0;
		tick(1);
		chk("cleared low cycles", highs[0] - 16'h1, highs[2]);
		nv = cmp[2] + 10'h010;
		set_cmp(2, nv);
		edge2(1'b0);
		wr(`IDX_CTRL0, 8'hC0, 2'h0);
		wr(`IDX_CTRL0, 8'h80, 2'h0);
		rc(`IDX_CTRL0, 8'h40, 8'h00);
		measure(1);
		wr(`IDX_CTRL0, 8'h40, 2'h0);
		tick(2);
		frz = pwm_out;
		window(200);
		for (int c = 0; c < 4; c++) chk("frozen level", frz[c] ? 200 : 0, highs[c]);
		rc(`IDX_CTRL0, 8'hC0, 8'h40);
		wr(`IDX_CTRL0, 8'hC0, 2'h0);
		poll_load();
		cmp[2] = nv;
		measure(1);
		// slowest prescale: one period spans sixteen times as many cycles
		wr(`IDX_CTRL2, 8'h0C, 2'h0);
		rc(`IDX_CTRL2, 8'hFF, 8'h0C);
		measure(16);
		wr(`IDX_CTRL2, 8'h00, 2'h0);
		// brake by software, by stopped run, and by the pin in both polarities
		wr(`IDX_CTRL1, 8'h0A, 2'h0);
		chk("brake disabled", 2'h1, pwm_out[1:0]);
		wr(`IDX_CTRL1, 8'h1A, 2'h0);
		tick(2);
		chk("software brake", 4'hA, pwm_out);
		wr(`IDX_CTRL1, 8'h9A, 2'h0);
		tick(2);
		chk("brake restored", 2'h1, pwm_out[1:0]);
		wr(`IDX_CTRL0, 8'h00, 2'h0);
		tick(2);
		chk("stopped brake", 4'hA, pwm_out);
		for (int p = 0; p < 2; p++) begin
			// brake off while the switch level flips, so no stray pin brake
			wr(`IDX_CTRL1, 8'h0A, 2'h0);
			lvl <= p[0];
			wr(`IDX_CTRL0, 8'h80, 2'h0);
			wr(`IDX_CTRL1, {1'b0, p[0], 6'h3A}, 2'h0);
			tick(3);
			chk("pin idle", 2'h1, pwm_out[1:0]);
			press <= 1'b1;
			tick(4);
			chk("pin brake", 4'hA, pwm_out);
			rc(`IDX_CTRL0, 8'h80, 8'h00);
			rc(`IDX_CTRL2, 8'h01, 8'h01);
			press <= 1'b0;
			tick(3);
			wr(`IDX_CTRL2, 8'h00, 2'h0);
			rc(`IDX_CTRL2, 8'hFF, 8'h00);
			chk("pin released", 2'h1, pwm_out[1:0]);
		end
		report_and_stop();
	end
endmodule : test_four_channel_pwm_with_brake
`default_nettype wire
